// file: rtl/phy_opt_pkg.sv
// Purpose: constants and types for the receive/transmit option register bank
// Assumes: AXI4-Lite, 32-bit data, register index times four is the byte address
// Notes: registers hold 16 bits in the low half of the word
package phy_opt_pkg;
	localparam int          REG_W          = 16;
	localparam logic [3:0]  IDX_XOVER      = 4'h9;
	localparam logic [3:0]  IDX_DUPLEX     = 4'ha;
	localparam logic [15:0] XOVER_RESET    = 16'h0000;
	localparam logic [15:0] DUPLEX_RESET   = 16'h0000;
	localparam logic [15:0] XOVER_MASK     = 16'h0022;
	localparam logic [15:0] DUPLEX_MASK    = 16'h0026;
	localparam int          BIT_ROBUST     = 5;
	localparam int          BIT_FAST_DV    = 1;
	localparam int          BIT_EXT_FD     = 5;
	localparam int          BIT_IDLE_ERR   = 2;
	localparam int          BIT_ODD_DIS    = 1;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'h0,
		RX_GOT_J = 2'h1,
		RX_DATA  = 2'h3
	} rx_state_t;

	typedef struct packed {
		logic valid;
		logic is_j;
		logic is_k;
		logic is_end;
		logic sym_err;
	} rx_sym_t;

	typedef struct packed {
		logic an_enable;
		logic forced_100tx;
		logic lp_forced_100tx;
		logic std_full_duplex;
	} duplex_in_t;
endpackage

// file: rtl/phy_rx_tx_option_control.sv
// Purpose: option register bank with receive delimiter, duplex and odd-nibble logic
// Assumes: one clock, one MII nibble per aclk cycle, symbol flags from same-clock logic
// Notes: MII transmit inputs come from outside and pass two flip-flops first
`timescale 1ns/1ps
`default_nettype none
module phy_rx_tx_option_control
	import phy_opt_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire rx_sym_t     rx_sym,
	input  wire duplex_in_t  duplex_in,
	input  wire logic        tx_en_pin,
	input  wire logic        tx_er_pin,
	output var  logic        rx_dv,
	output var  logic        rx_er,
	output var  logic        tx_en_out,
	output var  logic        tx_er_out,
	output var  logic        robust_mdix_en,
	output var  logic        full_duplex
);
	// register file
	logic [15:0] xover_reg;
	logic [15:0] xover_next;
	logic [15:0] duplex_reg;
	logic [15:0] duplex_next;

	// bus slave state
	logic        aw_have_reg;
	logic        aw_have_next;
	logic [7:0]  aw_addr_reg;
	logic [7:0]  aw_addr_next;
	logic        w_have_reg;
	logic        w_have_next;
	logic [31:0] w_data_reg;
	logic [31:0] w_data_next;
	logic [3:0]  w_strb_reg;
	logic [3:0]  w_strb_next;
	logic        bvalid_reg;
	logic        bvalid_next;
	logic [1:0]  bresp_reg;
	logic [1:0]  bresp_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;
	logic        awready_reg;
	logic        awready_next;
	logic        wready_reg;
	logic        wready_next;
	logic        arready_reg;
	logic        arready_next;

	logic [7:0]  xover_addr;
	logic [7:0]  duplex_addr;
	logic [15:0] wr_bits;
	logic [15:0] wr_lanes;
	logic        wr_go;

	assign xover_addr  = {2'h0, IDX_XOVER, 2'h0};
	assign duplex_addr = {2'h0, IDX_DUPLEX, 2'h0};
	assign wr_lanes    = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign wr_bits     = w_data_reg[REG_W-1:0];
	// a write commits once address and data are both held and no response is pending
	assign wr_go       = aw_have_reg && w_have_reg && !bvalid_reg;

	always_comb begin
		aw_have_next = aw_have_reg;
		aw_addr_next = aw_addr_reg;
		w_have_next  = w_have_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		xover_next   = xover_reg;
		duplex_next  = duplex_reg;
		if (s_axi_awvalid && !aw_have_reg) begin
			aw_have_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_reg) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = RESP_OKAY;
			if (aw_addr_reg == xover_addr) begin
				// only the two option bits are writable
				xover_next = (xover_reg & ~(wr_lanes & XOVER_MASK))
					| (wr_bits & wr_lanes & XOVER_MASK);
			end else if (aw_addr_reg == duplex_addr) begin
				duplex_next = (duplex_reg & ~(wr_lanes & DUPLEX_MASK))
					| (wr_bits & wr_lanes & DUPLEX_MASK);
			end else begin
				bresp_next = RESP_SLVERR;
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// ready follows the slot's next state so the port leaves a flop directly
		awready_next = !aw_have_next;
		wready_next  = !w_have_next;
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			// upper half and reserved bits read zero
			if (s_axi_araddr == xover_addr) begin
				rdata_next = {16'h0000, xover_reg};
			end else if (s_axi_araddr == duplex_addr) begin
				rdata_next = {16'h0000, duplex_reg};
			end else begin
				rdata_next = 32'h0000_0000;
				rresp_next = RESP_SLVERR;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xover_reg   <= XOVER_RESET;
			duplex_reg  <= DUPLEX_RESET;
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_have_reg  <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			arready_reg <= 1'b1;
		end else begin
			xover_reg   <= xover_next;
			duplex_reg  <= duplex_next;
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg  <= w_have_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			arready_reg <= arready_next;
		end
	end

	// ready is high while the holding slot is empty, so each channel moves once
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	logic fast_dv;
	logic idle_err_en;
	logic odd_dis;
	assign fast_dv     = xover_reg[BIT_FAST_DV];
	assign idle_err_en = duplex_reg[BIT_IDLE_ERR];
	assign odd_dis     = duplex_reg[BIT_ODD_DIS];

	// receive delimiter tracking
	rx_state_t rx_state_reg;
	rx_state_t rx_state_next;
	logic      rx_dv_reg;
	logic      rx_dv_next;
	logic      rx_er_reg;
	logic      rx_er_next;

	always_comb begin
		rx_state_next = rx_state_reg;
		rx_dv_next    = rx_dv_reg;
		rx_er_next    = 1'b0;
		unique case (rx_state_reg)
			RX_IDLE: begin
				rx_dv_next = 1'b0;
				if (rx_sym.valid && rx_sym.is_j) begin
					rx_state_next = RX_GOT_J;
					rx_dv_next    = fast_dv;
				end else if (rx_sym.valid && rx_sym.sym_err) begin
					rx_er_next = idle_err_en;
				end
			end
			RX_GOT_J: begin
				if (rx_sym.valid && rx_sym.is_k) begin
					rx_state_next = RX_DATA;
					rx_dv_next    = 1'b1;
				end else if (rx_sym.valid) begin
					// bad delimiter: drop the frame; only an early RX_DV is flagged
					rx_state_next = RX_IDLE;
					rx_dv_next    = 1'b0;
					rx_er_next    = rx_dv_reg;
				end
			end
			RX_DATA: begin
				if (rx_sym.valid && rx_sym.is_end) begin
					rx_state_next = RX_IDLE;
					rx_dv_next    = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_reg <= RX_IDLE;
			rx_dv_reg    <= 1'b0;
			rx_er_reg    <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_dv_reg    <= rx_dv_next;
			rx_er_reg    <= rx_er_next;
		end
	end

	assign rx_dv = rx_dv_reg;
	assign rx_er = rx_er_reg;

	// transmit pins are synchronised before use; the pin's first stage feeds only the second
	logic [1:0] tx_meta_reg;
	logic [1:0] tx_sync_reg;
	logic       tx_en_s;
	logic       tx_er_s;
	assign tx_en_s = tx_sync_reg[1];
	assign tx_er_s = tx_sync_reg[0];

	logic tx_odd_reg;
	logic tx_odd_next;
	logic tx_en_reg;
	logic tx_en_next;
	logic tx_er_reg;
	logic tx_er_next;

	always_comb begin
		tx_odd_next = 1'b0;
		tx_en_next  = tx_en_s;
		tx_er_next  = tx_en_s && tx_er_s;
		if (tx_en_s) begin
			tx_odd_next = !tx_odd_reg;
		end else if (tx_odd_reg && !odd_dis) begin
			// odd count of nibbles: pad one nibble and mark it bad
			tx_en_next = 1'b1;
			tx_er_next = 1'b1;
		end
		// with detection off the frame ends where the MAC ended it
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_meta_reg <= 2'h0;
			tx_sync_reg <= 2'h0;
			tx_odd_reg  <= 1'b0;
			tx_en_reg   <= 1'b0;
			tx_er_reg   <= 1'b0;
		end else begin
			tx_meta_reg <= {tx_en_pin, tx_er_pin};
			tx_sync_reg <= tx_meta_reg;
			tx_odd_reg  <= tx_odd_next;
			tx_en_reg   <= tx_en_next;
			tx_er_reg   <= tx_er_next;
		end
	end

	assign tx_en_out = tx_en_reg;
	assign tx_er_out = tx_er_reg;

	// crossover and duplex resolution
	logic mdix_reg;
	logic mdix_next;
	logic fd_reg;
	logic fd_next;

	always_comb begin
		mdix_next = xover_reg[BIT_ROBUST];
		fd_next   = duplex_in.std_full_duplex;
		if (duplex_reg[BIT_EXT_FD] && duplex_in.lp_forced_100tx
			&& (duplex_in.an_enable || duplex_in.forced_100tx)) begin
			fd_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mdix_reg <= 1'b0;
			fd_reg   <= 1'b0;
		end else begin
			mdix_reg <= mdix_next;
			fd_reg   <= fd_next;
		end
	end

	assign robust_mdix_en = mdix_reg;
	assign full_duplex    = fd_reg;
endmodule
`default_nettype wire

// file: verification/phy_opt_props.sv
// Purpose: port-level checks of the option register bank
// Assumes: one clock, synchronous active-low reset
// Notes: register contents are hidden here, so outputs are tied to their causes
`timescale 1ns/1ps
`default_nettype none
module phy_opt_props
	import phy_opt_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire rx_sym_t    rx_sym,
	input wire duplex_in_t duplex_in,
	input wire logic       tx_en_pin,
	input wire logic       rx_dv,
	input wire logic       rx_er,
	input wire logic       tx_en_out,
	input wire logic       robust_mdix_en,
	input wire logic       full_duplex
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// two synchroniser stages plus the output register
	sequence tx_rise; !tx_en_pin ##1 tx_en_pin; endsequence
	sequence tx_seen; ##3 tx_en_out; endsequence
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_robust_bus: assert property ($changed(robust_mdix_en) |-> $past(s_axi_bvalid))
		else $error("crossover enable moved without a write");
	a_dv_cause: assert property ($rose(rx_dv) |-> $past(rx_sym.valid && (rx_sym.is_j || rx_sym.is_k)))
		else $error("rx_dv rose without a delimiter");
	a_er_cause: assert property (rx_er |-> $past(rx_sym.valid))
		else $error("rx_er without a symbol");
	a_fd_std: assert property (duplex_in.std_full_duplex |=> full_duplex)
		else $error("standard full duplex lost");
	a_fd_cause: assert property (full_duplex |-> $past(duplex_in.std_full_duplex
		|| (duplex_in.lp_forced_100tx && (duplex_in.an_enable || duplex_in.forced_100tx))))
		else $error("full duplex without cause");
	a_tx_latency: assert property (tx_rise |-> tx_seen)
		else $error("transmit enable latency wrong");
endmodule
bind phy_rx_tx_option_control phy_opt_props i_phy_opt_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .rx_sym, .duplex_in, .tx_en_pin, .rx_dv, .rx_er, .tx_en_out,
	.robust_mdix_en, .full_duplex);
`default_nettype wire

// file: verification/mac_model.sv
// Purpose: symbol source and MII transmit side facing the block
// Assumes: one symbol or nibble per aclk cycle
// Notes: released flags show their inverse so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module mac_model
	import phy_opt_pkg::*;
(
	input  wire logic    aclk,
	output var  rx_sym_t rx_sym,
	output var  logic    tx_en_pin,
	output var  logic    tx_er_pin
);
	initial begin
		rx_sym = 5'h00;
		tx_en_pin = 1'b0;
		tx_er_pin = 1'b0;
	end
	task automatic sym(input rx_sym_t s);
		@(posedge aclk);
		rx_sym <= s;
	endtask
	task automatic idle();
		@(posedge aclk);
		rx_sym <= {1'b0, ~rx_sym[3:0]};
	endtask
	task automatic tx_burst(input int n, input logic err);
		repeat (n) begin
			@(posedge aclk);
			tx_en_pin <= 1'b1;
			tx_er_pin <= err;
		end
		@(posedge aclk);
		tx_en_pin <= 1'b0;
		tx_er_pin <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: verification/phy_rx_tx_option_control_tb.sv
// Purpose: self-checking bench of the option register bank
// Assumes: AXI4-Lite master tasks, symbol and MII model
// Notes: expected values follow the writable-bit masks by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
module phy_rx_tx_option_control_tb
	import phy_opt_pkg::*;
();
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] e;} row_t;
	localparam rx_sym_t J = 5'h18, K = 5'h14, D = 5'h10, E = 5'h12, S = 5'h11;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, tx_en_pin, tx_er_pin, seen;
	logic        rx_dv, rx_er, tx_en_out, tx_er_out, robust, full_duplex;
	logic [1:0]  bresp, rresp;
	logic [3:0]  ne, nr;
	rx_sym_t     rx_sym;
	duplex_in_t  duplex_in = 4'h0;
	int          n_fail = 0, cmp_count = 0;
	row_t        rows[5] = '{'{8'h24, 32'hffffffff, 32'h22, 2'h0}, '{8'h28, 32'hffffffff, 32'h26, 2'h0},
		'{8'h24, 32'h0000ffdd, 32'h0, 2'h0}, '{8'h28, 32'h0000ffd9, 32'h0, 2'h0}, '{8'h30, 32'h1, 32'h0, 2'h2}};
	phy_rx_tx_option_control i_phy_rx_tx_option_control (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_sym(rx_sym),
		.duplex_in(duplex_in), .tx_en_pin(tx_en_pin), .tx_er_pin(tx_er_pin), .rx_dv(rx_dv), .rx_er(rx_er),
		.tx_en_out(tx_en_out), .tx_er_out(tx_er_out), .robust_mdix_en(robust), .full_duplex(full_duplex));
	mac_model i_mac_model (.aclk(aclk), .rx_sym(rx_sym), .tx_en_pin(tx_en_pin), .tx_er_pin(tx_er_pin));
	initial begin
		forever #50 aclk = ~aclk;
	end
	task automatic end_of_test();
		if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		`CHK(rdata, d)
		`CHK(rresp, er)
	endtask
	// rx_er is a one-cycle pulse, so it is gathered over a short window
	task automatic watch_er();
		seen = 1'b0;
		repeat (4) begin
			@(posedge aclk);
			seen = seen | rx_er;
		end
	endtask
	task automatic rx_case(input logic fast);
		wr(8'h24, fast ? 32'h2 : 32'h0, 2'h0);
		i_mac_model.sym(J); i_mac_model.idle(); repeat (2) @(posedge aclk);
		`CHK(rx_dv, fast)
		i_mac_model.sym(K); i_mac_model.sym(D); @(posedge aclk);
		`CHK(rx_dv, 1'b1)
		i_mac_model.sym(E); i_mac_model.idle(); repeat (2) @(posedge aclk);
		`CHK(rx_dv, 1'b0)
		i_mac_model.sym(J); i_mac_model.sym(D); i_mac_model.idle(); watch_er();
		`CHK(seen, fast)
	endtask
	task automatic tx_case(input logic dis, input int n, input logic err, input logic [3:0] en, input logic [3:0] er);
		wr(8'h28, dis ? 32'h2 : 32'h0, 2'h0);
		ne = 4'h0; nr = 4'h0;
		fork
			i_mac_model.tx_burst(n, err);
			repeat (12) begin @(posedge aclk); ne = ne + tx_en_out; nr = nr + tx_er_out; end
		join
		`CHK(ne, en)
		`CHK(nr, er)
	endtask
	initial begin
		repeat (5000) @(posedge aclk);
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h24, 32'h0, 2'h0);
		rd(8'h28, 32'h0, 2'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, rows[i].e);
			rd(rows[i].a, rows[i].r, rows[i].e);
		end
		// only the upper byte lane enabled: the writable bits all sit in the lower lane
		wstrb <= 4'h2;
		wr(8'h28, 32'h26, 2'h0);
		rd(8'h28, 32'h0, 2'h0);
		wstrb <= 4'hf;
		wr(8'h24, 32'h20, 2'h0); repeat (2) @(posedge aclk);
		`CHK(robust, 1'b1)
		rx_case(1'b0);
		rx_case(1'b1);
		wr(8'h28, 32'h4, 2'h0); i_mac_model.sym(S); i_mac_model.idle(); watch_er();
		`CHK(seen, 1'b1)
		wr(8'h28, 32'h0, 2'h0); i_mac_model.sym(S); i_mac_model.idle(); watch_er();
		`CHK(seen, 1'b0)
		wr(8'h24, 32'h20, 2'h0); // robust crossover bit set; the forced-mode duplex check does not use it
		duplex_in <= 4'h6; repeat (3) @(posedge aclk);
		`CHK(full_duplex, 1'b0)
		wr(8'h28, 32'h20, 2'h0); repeat (3) @(posedge aclk);
		`CHK(full_duplex, 1'b1)
		wr(8'h28, 32'h0, 2'h0); duplex_in <= 4'h1; repeat (3) @(posedge aclk);
		`CHK(full_duplex, 1'b1)
		tx_case(1'b0, 3, 1'b0, 4'h4, 4'h1);
		tx_case(1'b1, 3, 1'b0, 4'h3, 4'h0);
		tx_case(1'b0, 4, 1'b0, 4'h4, 4'h0);
		tx_case(1'b0, 3, 1'b1, 4'h4, 4'h4);
		wr(8'h24, 32'h22, 2'h0);
		aresetn <= 1'b0; repeat (2) @(posedge aclk); aresetn <= 1'b1;
		rd(8'h24, 32'h0, 2'h0);
		`CHK(robust, 1'b0)
		end_of_test();
	end
endmodule
`default_nettype wire
